// ### include/abr_map.svh
`ifndef ABR_MAP_SVH
`define ABR_MAP_SVH

// audio bus word and source numbering
`define ABR_WORD_W      24
`define ABR_NUM_SRC     8
`define ABR_NUM_RXSRC   5
`define ABR_SRC_CPU0    5

// serial port slot timing, in bit clock periods
`define ABR_SAI_FIT     8'd24
`define ABR_SAI_CNT_MAX 8'hff

// link rates used to derive the frame generator cell divider
`define ABR_CLK_KHZ     250000
`define ABR_IEC_UI_KHZ  6144

// frame generator layout: preambles, bit slots, block length
`define ABR_IEC_PRE_X   8'he2
`define ABR_IEC_PRE_Y   8'he4
`define ABR_IEC_PRE_Z   8'he8
`define ABR_IEC_AUX_END 5'd28
`define ABR_IEC_CS_SLOT 5'd30
`define ABR_IEC_PAR_SLT 5'd31
`define ABR_IEC_LAST_FR 8'd191
`define ABR_IEC_LAST_UI 6'h3f

// receive decoder: cell sums and interval counter limit
`define ABR_IEC_PRE_UI  4'd8
`define ABR_IEC_LONG    2'd3
`define ABR_IEC_LAST_BT 5'd27
`define ABR_IEC_CNT_MAX 12'hfff

`endif

// ### include/abr_pkg.sv
package abr_pkg;

   // receive decoder states, gray along hunt -> preamble -> data
   typedef enum logic [1:0]
   {
      ABR_RX_HUNT = 2'b00,
      ABR_RX_PRE  = 2'b01,
      ABR_RX_DATA = 2'b11
   } abr_rx_state_type;

   // source of both digital audio outputs
   typedef enum logic
   {
      ABR_OUT_GEN  = 1'b0,
      ABR_OUT_PASS = 1'b1
   } abr_iec_mode_type;

endpackage

// ### rtl/abr_audio_bus_router.sv
`timescale 1ns/100ps
`include "abr_map.svh"

module abr_audio_bus_router
#(
   parameter int IEC_UI_DIV = `ABR_CLK_KHZ / `ABR_IEC_UI_KHZ
)
(
   // clock and reset
   input  wire logic                     clk_i,
   input  wire logic                     resetn_i,
   // serial audio pins
   input  wire logic [3:0]               sai_sclk_i,
   input  wire logic [3:0]               sai_ws_i,
   input  wire logic                     sai0_din_i,
   input  wire logic                     sai2_din_i,
   input  wire logic                     sai3_din_i,
   output wire logic                     sai0_dout_o,
   output wire logic                     sai1_dout_o,
   // serial audio control
   input  wire logic [3:0]               sai_fmt_eiaj_i,
   input  wire logic [2:0]               sai0_src_sel_i,
   input  wire logic [2:0]               sai1_src_sel_i,
   // digital audio pins
   input  wire logic [3:0]               iec_in_i,
   output logic                          iec_out_pro_o,
   output logic                          iec_out_con_o,
   // digital audio control
   input  wire logic [1:0][1:0]          iec_rx_pin_sel_i,
   input  wire abr_pkg::abr_iec_mode_type iec_mode_i,
   input  wire logic [1:0]               iec_pass_sel_i,
   input  wire logic [2:0]               iec_src_sel_i,
   // processor read taps
   input  wire logic [2:0][2:0]          cpu_rd_sel_i,
   output logic [2:0][23:0]              cpu_rd_left_o,
   output logic [2:0][23:0]              cpu_rd_right_o,
   // processor write sources
   input  wire logic [2:0]               cpu_wr_stb_i,
   input  wire logic [2:0][23:0]         cpu_wr_left_i,
   input  wire logic [2:0][23:0]         cpu_wr_right_i
);
   import abr_pkg::*;

   // ****************************************************************
   // helper functions
   // ****************************************************************

   // classify a biphase interval as one, two or three cells
   function automatic logic [1:0] iec_cls(input logic [12:0] len,
                                          input logic [11:0] mn);
      logic [15:0] twice;
      logic [15:0] lim2;
      logic [15:0] lim3;
      twice = {2'b00, len, 1'b0};
      lim2  = 16'({4'h0, mn} * 16'd3);
      lim3  = 16'({4'h0, mn} * 16'd5);
      if (twice < lim2)
         iec_cls = 2'd1;
      else if (twice < lim3)
         iec_cls = 2'd2;
      else
         iec_cls = `ABR_IEC_LONG;
   endfunction

   // biphase-mark level of the next cell
   function automatic logic iec_enc(input logic       lvl,
                                    input logic       start,
                                    input logic [5:0] ui,
                                    input logic [7:0] pat,
                                    input logic       dbit);
      if (ui[5:3] == 3'h0)
         iec_enc = start ^ pat[3'h7 - ui[2:0]];
      else if (!ui[0])
         iec_enc = ~lvl;
      else
         iec_enc = lvl ^ dbit;
   endfunction

   // ****************************************************************
   // input synchronisers
   // ****************************************************************

   // pins: [3:0] bit clocks, [7:4] word clocks, [11:8] data, [15:12] iec
   logic [15:0] s1_q;
   logic [15:0] s2_q;
   logic [15:0] s3_q;
   wire  [15:0] async_w = {iec_in_i, sai3_din_i, sai2_din_i, 1'b0,
                           sai0_din_i, sai_ws_i, sai_sclk_i};

   // two stages before use, third for edges; needs sclk <= clk/3
   always_ff @(posedge clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         s1_q <= 16'h0000;
         s2_q <= 16'h0000;
         s3_q <= 16'h0000;
      end
      else
      begin
         s1_q <= async_w;
         s2_q <= s1_q;
         s3_q <= s2_q;
      end
   end

   // ****************************************************************
   // audio bus
   // ****************************************************************

   logic [23:0] bus_l_q [`ABR_NUM_SRC];
   logic [23:0] bus_r_q [`ABR_NUM_SRC];
   logic [3:0]  sai_stb_w;
   logic [3:0]  sai_left_w;
   logic [23:0] sai_word_w [4];
   logic [1:0]  dout_w;
   logic [1:0]  iec_stb_w;
   logic [1:0]  iec_left_w;
   logic [23:0] iec_word_w [2];
   logic [4:0]  src_stb_w;
   logic [4:0]  src_left_w;
   logic [23:0] src_word_w [`ABR_NUM_RXSRC];

   // receiver sources: sai0, sai2, sai3, iec rx 0, iec rx 1
   assign src_stb_w     = {iec_stb_w, sai_stb_w[3:2], sai_stb_w[0]};
   assign src_left_w    = {iec_left_w, sai_left_w[3:2], sai_left_w[0]};
   assign src_word_w[0] = sai_word_w[0];
   assign src_word_w[1] = sai_word_w[2];
   assign src_word_w[2] = sai_word_w[3];
   assign src_word_w[3] = iec_word_w[0];
   assign src_word_w[4] = iec_word_w[1];

   // each source slot keeps its last word until the next one
   always_ff @(posedge clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         for (int s = 0; s < `ABR_NUM_SRC; s++)
         begin
            bus_l_q[s] <= 24'h000000;
            bus_r_q[s] <= 24'h000000;
         end
      end
      else
      begin
         for (int s = 0; s < `ABR_NUM_RXSRC; s++)
         begin
            if (src_stb_w[s] && src_left_w[s])
               bus_l_q[s] <= src_word_w[s];
            else if (src_stb_w[s])
               bus_r_q[s] <= src_word_w[s];
         end
         for (int c = 0; c < 3; c++)
         begin
            if (cpu_wr_stb_i[c])
            begin
               bus_l_q[`ABR_SRC_CPU0 + c] <= cpu_wr_left_i[c];
               bus_r_q[`ABR_SRC_CPU0 + c] <= cpu_wr_right_i[c];
            end
         end
      end
   end

   // read taps sample their chosen source every cycle
   always_ff @(posedge clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         cpu_rd_left_o  <= '0;
         cpu_rd_right_o <= '0;
      end
      else
      begin
         for (int t = 0; t < 3; t++)
         begin
            cpu_rd_left_o[t]  <= bus_l_q[cpu_rd_sel_i[t]];
            cpu_rd_right_o[t] <= bus_r_q[cpu_rd_sel_i[t]];
         end
      end
   end

   // ****************************************************************
   // serial audio ports
   // ****************************************************************

   // four ports; port 0 in/out, port 1 out, ports 2 and 3 in
   for (genvar p = 0; p < 4; p++)
   begin : g_sai
      logic        ws_q;
      logic [7:0]  cnt_q;
      logic [7:0]  len_q;
      logic [23:0] sr_q;
      logic        stb_q;
      logic        left_q;
      logic [23:0] word_q;
      wire         eiaj_w = sai_fmt_eiaj_i[p];
      wire         rise_w = s2_q[p] & ~s3_q[p];
      wire         fall_w = ~s2_q[p] & s3_q[p];
      wire         chg_w  = rise_w & (s2_q[4+p] != ws_q);
      wire         fits_w = cnt_q < `ABR_SAI_FIT;
      wire  [23:0] shf_w  = {sr_q[22:0], s2_q[8+p]};
      wire  [23:0] cap_w  = (eiaj_w | ~fits_w) ? sr_q : shf_w;

      // slot counter and receive shifter, edge driven only
      always_ff @(posedge clk_i or negedge resetn_i)
      begin
         if (!resetn_i)
         begin
            ws_q   <= 1'b0;
            cnt_q  <= 8'h00;
            len_q  <= 8'h00;
            sr_q   <= 24'h000000;
            stb_q  <= 1'b0;
            left_q <= 1'b0;
            word_q <= 24'h000000;
         end
         else
         begin
            stb_q <= chg_w;
            if (rise_w)
               ws_q <= s2_q[4+p];
            if (chg_w)
            begin
               cnt_q  <= 8'h00;
               len_q  <= 8'(cnt_q + 8'd1);
               sr_q   <= shf_w;
               word_q <= cap_w;
               left_q <= eiaj_w ? ws_q : ~ws_q;
            end
            else if (rise_w)
            begin
               if (cnt_q != `ABR_SAI_CNT_MAX)
                  cnt_q <= 8'(cnt_q + 8'd1);
               if (eiaj_w | fits_w)
                  sr_q <= shf_w;
            end
         end
      end

      assign sai_stb_w[p]  = stb_q & (p != 1);
      assign sai_left_w[p] = left_q;
      assign sai_word_w[p] = word_q;

      if (p < 2)
      begin : g_tx
         logic [23:0] txw_q;
         logic        dout_q;
         wire  [2:0]  sel_w   = (p == 0) ? sai0_src_sel_i : sai1_src_sel_i;
         wire         nleft_w = eiaj_w ? s2_q[4+p] : ~s2_q[4+p];
         wire  [8:0]  rem_w   = 9'({1'b0, len_q} - {1'b0, cnt_q} - 9'd2);
         wire  [7:0]  idx_w   = 8'(8'd23 - cnt_q);
         wire         rj_ok_w = ~rem_w[8] & (rem_w < 9'd24);
         wire         bit_w   = eiaj_w ? (rj_ok_w & txw_q[rem_w[4:0]])
                                       : (fits_w & txw_q[idx_w[4:0]]);

         // fetch the new channel's word, shift out on falling edges
         always_ff @(posedge clk_i or negedge resetn_i)
         begin
            if (!resetn_i)
            begin
               txw_q  <= 24'h000000;
               dout_q <= 1'b0;
            end
            else
            begin
               if (chg_w)
                  txw_q <= nleft_w ? bus_l_q[sel_w] : bus_r_q[sel_w];
               if (fall_w)
                  dout_q <= bit_w;
            end
         end
         assign dout_w[p] = dout_q;
      end
   end

   assign sai0_dout_o = dout_w[0];
   assign sai1_dout_o = dout_w[1];

   // ****************************************************************
   // digital audio receivers
   // ****************************************************************

   for (genvar r = 0; r < 2; r++)
   begin : g_iecrx
      abr_rx_state_type st_q;
      logic [11:0] cnt_q;
      logic [11:0] min_q;
      logic [3:0]  acc_q;
      logic        half_q;
      logic        left_q;
      logic [4:0]  nb_q;
      logic [27:0] sr_q;
      logic        stb_q;
      logic        pleft_q;
      logic [23:0] word_q;
      wire  [1:0]  pin_w = iec_rx_pin_sel_i[r];
      wire         edge_w = s2_q[12+pin_w] ^ s3_q[12+pin_w];
      wire  [12:0] len_w = 13'({1'b0, cnt_q} + 13'd1);
      wire  [1:0]  k_w = iec_cls(len_w, min_q);
      wire  [3:0]  acc_n_w = 4'(acc_q + {2'b00, k_w});
      wire  [27:0] nsr_w = {k_w == 2'd1, sr_q[27:1]};

      // biphase-mark decode from measured transition intervals
      always_ff @(posedge clk_i or negedge resetn_i)
      begin
         if (!resetn_i)
         begin
            st_q    <= ABR_RX_HUNT;
            cnt_q   <= 12'h000;
            min_q   <= `ABR_IEC_CNT_MAX;
            acc_q   <= 4'h0;
            half_q  <= 1'b0;
            left_q  <= 1'b0;
            nb_q    <= 5'h00;
            sr_q    <= 28'h0000000;
            stb_q   <= 1'b0;
            pleft_q <= 1'b0;
            word_q  <= 24'h000000;
         end
         else if (!edge_w)
         begin
            stb_q <= 1'b0;
            if (cnt_q != `ABR_IEC_CNT_MAX)
               cnt_q <= 12'(cnt_q + 12'd1);
            else
            begin
               min_q <= `ABR_IEC_CNT_MAX;
               st_q  <= ABR_RX_HUNT;
            end
         end
         else
         begin
            stb_q <= 1'b0;
            cnt_q <= 12'h000;
            if (len_w < {1'b0, min_q})
               min_q <= len_w[11:0];
            case (st_q)
               ABR_RX_HUNT:
                  if (k_w == `ABR_IEC_LONG)
                  begin
                     st_q  <= ABR_RX_PRE;
                     acc_q <= 4'd3;
                  end
               ABR_RX_PRE:
               begin
                  if (acc_q == 4'd3)
                     left_q <= (k_w != 2'd2); // preamble y is right
                  acc_q <= acc_n_w;
                  if (acc_n_w == `ABR_IEC_PRE_UI)
                  begin
                     st_q   <= ABR_RX_DATA;
                     nb_q   <= 5'h00;
                     half_q <= 1'b0;
                  end
                  else if (acc_n_w > `ABR_IEC_PRE_UI)
                     st_q <= ABR_RX_HUNT;
               end
               ABR_RX_DATA:
                  if (k_w == `ABR_IEC_LONG)
                  begin
                     st_q  <= ABR_RX_PRE;
                     acc_q <= 4'd3;
                  end
                  else if (k_w == 2'd2 && half_q)
                     st_q <= ABR_RX_HUNT;
                  else if (k_w == 2'd1 && !half_q)
                     half_q <= 1'b1;
                  else
                  begin
                     sr_q   <= nsr_w;
                     half_q <= 1'b0;
                     nb_q   <= 5'(nb_q + 5'd1);
                     if (nb_q == `ABR_IEC_LAST_BT)
                     begin
                        st_q    <= ABR_RX_HUNT;
                        stb_q   <= ~^nsr_w;
                        word_q  <= nsr_w[23:0];
                        pleft_q <= left_q;
                     end
                  end
               default:
                  st_q <= ABR_RX_HUNT;
            endcase
         end
      end

      assign iec_stb_w[r]  = stb_q;
      assign iec_left_w[r] = pleft_q;
      assign iec_word_w[r] = word_q;
   end

   // ****************************************************************
   // digital audio transmitter
   // ****************************************************************

   logic [7:0]  div_q;
   logic [5:0]  ui_q;
   logic        sf_q;
   logic [7:0]  frm_q;
   logic [1:0]  lvl_q;
   logic [1:0]  start_q;
   logic [23:0] txw_q;
   logic [1:0]  lvl_d;
   logic [1:0]  cs_w;
   logic [1:0]  dbit_w;

   // cell enable, next counters, preamble and slot decode
   wire         ui_en_w = div_q == 8'(IEC_UI_DIV - 1);
   wire         wrap_w  = ui_q == `ABR_IEC_LAST_UI;
   wire  [5:0]  ui_n_w  = 6'(ui_q + 6'd1);
   wire         sf_n_w  = wrap_w ? ~sf_q : sf_q;
   wire  [7:0]  frm_n_w = ~(wrap_w & sf_q) ? frm_q :
                          (frm_q == `ABR_IEC_LAST_FR) ? 8'h00 :
                          8'(frm_q + 8'd1);
   wire  [7:0]  pre_w   = sf_n_w ? `ABR_IEC_PRE_Y :
                          (frm_n_w == 8'h00) ? `ABR_IEC_PRE_Z :
                          `ABR_IEC_PRE_X;
   wire  [4:0]  slot_w  = ui_n_w[5:1];
   wire  [4:0]  aidx_w  = 5'(slot_w - 5'd4);
   wire         abit_w  = (slot_w < `ABR_IEC_AUX_END) & txw_q[aidx_w];
   wire  [1:0]  start_w = wrap_w ? lvl_q : start_q;
   wire         pass_w  = iec_mode_i == ABR_OUT_PASS;

   // status bit 0 marks the professional stream only
   assign cs_w = {1'b0, frm_n_w == 8'h00};
   for (genvar o = 0; o < 2; o++)
   begin : g_enc
      assign dbit_w[o] = abit_w |
                         ((slot_w == `ABR_IEC_CS_SLOT) & cs_w[o]) |
                         ((slot_w == `ABR_IEC_PAR_SLT) & (^txw_q ^ cs_w[o]));
      assign lvl_d[o] = iec_enc(lvl_q[o], start_w[o], ui_n_w, pre_w,
                                dbit_w[o]);
   end

   // frame generator stepping one cell per enable
   always_ff @(posedge clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         div_q   <= 8'h00;
         ui_q    <= `ABR_IEC_LAST_UI;
         sf_q    <= 1'b1;
         frm_q   <= `ABR_IEC_LAST_FR;
         lvl_q   <= 2'b00;
         start_q <= 2'b00;
         txw_q   <= 24'h000000;
      end
      else
      begin
         div_q <= ui_en_w ? 8'h00 : 8'(div_q + 8'd1);
         if (ui_en_w)
         begin
            ui_q    <= ui_n_w;
            sf_q    <= sf_n_w;
            frm_q   <= frm_n_w;
            lvl_q   <= lvl_d;
            start_q <= start_w;
            if (wrap_w)
               txw_q <= sf_n_w ? bus_r_q[iec_src_sel_i]
                               : bus_l_q[iec_src_sel_i];
         end
      end
   end

   // output select: generator or raw pass-through of one input pin
   always_ff @(posedge clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         iec_out_pro_o <= 1'b0;
         iec_out_con_o <= 1'b0;
      end
      else
      begin
         iec_out_pro_o <= pass_w ? s2_q[12+iec_pass_sel_i] : lvl_q[0];
         iec_out_con_o <= pass_w ? s2_q[12+iec_pass_sel_i] : lvl_q[1];
      end
   end

endmodule

// ### testbench/abr_audio_bus_router_properties.sv
`timescale 1ns/100ps

// port checker of the router
module abr_audio_bus_router_properties
#(
   parameter int IEC_UI_DIV = 40
)
(
   // clock and reset
   input wire logic                      clk_i,
   input wire logic                      resetn_i,
   // pins
   input wire logic [3:0]                sai_sclk_i,
   input wire logic                      sai0_dout_o,
   input wire logic                      sai1_dout_o,
   input wire logic [3:0]                iec_in_i,
   input wire logic                      iec_out_pro_o,
   input wire logic                      iec_out_con_o,
   // controls and processor ports
   input wire abr_pkg::abr_iec_mode_type iec_mode_i,
   input wire logic [1:0]                iec_pass_sel_i,
   input wire logic [2:0][2:0]           cpu_rd_sel_i,
   input wire logic [2:0][23:0]          cpu_rd_left_o,
   input wire logic [2:0][23:0]          cpu_rd_right_o,
   input wire logic [2:0]                cpu_wr_stb_i,
   input wire logic [2:0][23:0]          cpu_wr_left_i,
   input wire logic [2:0][23:0]          cpu_wr_right_i
);
   import abr_pkg::*;

   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!resetn_i);

   // write strobe, then tap steady on that source
   sequence s_wr_tap(c);
      cpu_wr_stb_i[c] && cpu_rd_sel_i[c] == 3'(5 + c) ##1
         cpu_rd_sel_i[c] == 3'(5 + c) [*2];
   endsequence

   // output stage steady in pass mode
   sequence s_pass_steady;
      (iec_mode_i == ABR_OUT_PASS && $stable(iec_pass_sel_i)) [*4];
   endsequence

   // write sources seen by the taps two cycles on
   a_wr_tap0_left : assert property (s_wr_tap(0) |->
      cpu_rd_left_o[0] == $past(cpu_wr_left_i[0], 2))
      else $error("tap 0 missed write word");
   a_wr_tap1_right : assert property (s_wr_tap(1) |->
      cpu_rd_right_o[1] == $past(cpu_wr_right_i[1], 2))
      else $error("tap 1 missed write word");
   a_wr_tap2_left : assert property (s_wr_tap(2) |->
      cpu_rd_left_o[2] == $past(cpu_wr_left_i[2], 2))
      else $error("tap 2 missed write word");
   a_src_hold : assert property (
      (cpu_rd_sel_i[2] == 3'h7 && !cpu_wr_stb_i[2]) [*3]
      |-> $stable(cpu_rd_left_o[2]))
      else $error("write source word changed without strobe");

   // pass-through routing and twin outputs
   a_pass_route : assert property (s_pass_steady |->
      iec_out_pro_o == $past(iec_in_i[iec_pass_sel_i], 3))
      else $error("pass output not the selected pin");
   a_pass_twin : assert property (s_pass_steady |->
      iec_out_pro_o == iec_out_con_o)
      else $error("digital outputs differ in pass mode");

   // clean start and quiet serial outputs
   a_reset_clear : assert property ($rose(resetn_i) |->
      (cpu_rd_left_o == '0 && cpu_rd_right_o == '0))
      else $error("taps not clear after reset");
   a_sai0_quiet : assert property ($stable(sai_sclk_i[0]) [*8] |->
      $stable(sai0_dout_o)) else $error("port 0 data moved, no clock");
   a_sai1_quiet : assert property ($stable(sai_sclk_i[1]) [*8] |->
      $stable(sai1_dout_o)) else $error("port 1 data moved, no clock");
endmodule

bind abr_audio_bus_router abr_audio_bus_router_properties
#(
   .IEC_UI_DIV(IEC_UI_DIV)
)
abr_props_i (.*);

// ### testbench/abr_codec_model.sv
`timescale 1ns/100ps

// serial codec, master of bit and word clock, iis framing
module abr_codec_model
(
   // serial pins
   output logic      sclk_o,
   output logic      ws_o,
   output logic      din_o,
   input  wire logic dout_i
);
   logic [23:0] rx_left;
   logic [23:0] rx_right;

   // clock stands still until a frame is played
   initial
   begin
      sclk_o = 1'b0;
      ws_o = 1'b0;
      din_o = 1'b0;
   end

   // lead slot, left, right, closing slot; 32 bit clocks each
   task automatic play(input logic [23:0] left, input logic [23:0] right);
      logic [23:0] word;
      for (int s = 0; s < 4; s++)
      begin
         word = (s == 2) ? right : left;
         for (int i = 0; i < 32; i++)
         begin
            sclk_o = 1'b0;
            ws_o = ~s[0];
            din_o = (i >= 1 && i <= 24) ? word[24 - i] : ~din_o;
            #62.5;
            sclk_o = 1'b1;
            if (s == 1 && i >= 1 && i <= 24)
               rx_left[24 - i] = dout_i;
            if (s == 2 && i >= 1 && i <= 24)
               rx_right[24 - i] = dout_i;
            #62.5;
         end
      end
      sclk_o = 1'b0;
   endtask
endmodule

// ### testbench/tb_top.sv
`timescale 1ns/100ps

module tb_top;
   import abr_pkg::*;

   // design pins and bench state
   logic             clk_i;
   logic             resetn_i;
   logic [3:0]       sai_sclk_i;
   logic [3:0]       sai_ws_i;
   logic             sai0_din_i;
   logic             din_b, sclk_a, sclk_b, ws_a, ws_b;
   logic             sai0_dout_o;
   logic             sai1_dout_o;
   logic [3:0]       sai_fmt_eiaj_i;
   logic [2:0]       sai0_src_sel_i;
   logic [2:0]       sai1_src_sel_i;
   logic [3:0]       iec_in_i;
   logic [3:0]       pass_pat;
   logic             loop_on;
   logic             iec_out_pro_o;
   logic             iec_out_con_o;
   logic [1:0][1:0]  iec_rx_pin_sel_i;
   abr_iec_mode_type iec_mode_i;
   logic [1:0]       iec_pass_sel_i;
   logic [2:0]       iec_src_sel_i;
   logic [2:0][2:0]  cpu_rd_sel_i;
   logic [2:0][23:0] cpu_rd_left_o;
   logic [2:0][23:0] cpu_rd_right_o;
   logic [2:0]       cpu_wr_stb_i;
   logic [2:0][23:0] cpu_wr_left_i;
   logic [2:0][23:0] cpu_wr_right_i;
   int               error_cnt, checks_done;

   // ports 1..3 share one codec; digital outputs may loop back
   assign sai_sclk_i = {sclk_b, sclk_b, sclk_b, sclk_a};
   assign sai_ws_i = {ws_b, ws_b, ws_b, ws_a};
   assign iec_in_i = loop_on ? {2'b00, iec_out_pro_o, iec_out_con_o}
                             : pass_pat;

   initial clk_i = 1'b0;
   always #2 clk_i = ~clk_i;

   abr_audio_bus_router #(.IEC_UI_DIV(4)) abr_audio_bus_router_i
   (
      .clk_i(clk_i), .resetn_i(resetn_i), .sai_sclk_i(sai_sclk_i),
      .sai_ws_i(sai_ws_i), .sai0_din_i(sai0_din_i), .sai2_din_i(din_b),
      .sai3_din_i(din_b), .sai0_dout_o(sai0_dout_o),
      .sai1_dout_o(sai1_dout_o), .sai_fmt_eiaj_i(sai_fmt_eiaj_i),
      .sai0_src_sel_i(sai0_src_sel_i), .sai1_src_sel_i(sai1_src_sel_i),
      .iec_in_i(iec_in_i), .iec_out_pro_o(iec_out_pro_o),
      .iec_out_con_o(iec_out_con_o), .iec_rx_pin_sel_i(iec_rx_pin_sel_i),
      .iec_mode_i(iec_mode_i), .iec_pass_sel_i(iec_pass_sel_i),
      .iec_src_sel_i(iec_src_sel_i), .cpu_rd_sel_i(cpu_rd_sel_i),
      .cpu_rd_left_o(cpu_rd_left_o), .cpu_rd_right_o(cpu_rd_right_o),
      .cpu_wr_stb_i(cpu_wr_stb_i), .cpu_wr_left_i(cpu_wr_left_i),
      .cpu_wr_right_i(cpu_wr_right_i)
   );

   abr_codec_model abr_codec_model_i (.sclk_o(sclk_a), .ws_o(ws_a),
      .din_o(sai0_din_i), .dout_i(sai0_dout_o));
   abr_codec_model abr_codec_model_b_i (.sclk_o(sclk_b), .ws_o(ws_b),
      .din_o(din_b), .dout_i(sai1_dout_o));

   // ****************************
   // compare, report and bus tasks
   // ****************************
   task automatic check24(input logic [23:0] exp, input logic [23:0] got);
      checks_done++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("mismatch at %0t: expected %h got %h", $time, exp, got);
      end
   endtask

   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   task automatic cpu_write(input int c, input logic [23:0] l,
                            input logic [23:0] r);
      cpu_wr_stb_i[c] = 1'b1;
      cpu_wr_left_i[c] = l;
      cpu_wr_right_i[c] = r;
      @(negedge clk_i);
      cpu_wr_stb_i[c] = 1'b0;
   endtask

   task automatic tap_read(input int t, input logic [2:0] sel,
                           input logic [23:0] l, input logic [23:0] r);
      cpu_rd_sel_i[t] = sel;
      repeat (3) @(negedge clk_i);
      check24(l, cpu_rd_left_o[t]);
      check24(r, cpu_rd_right_o[t]);
   endtask

   // ****************************
   // scenarios
   // ****************************
   task automatic test_cpu_path();
      for (int c = 0; c < 3; c++)
      begin
         cpu_rd_sel_i[c] = 3'(5 + c);
         cpu_write(c, 24'h800001 + 24'(c), 24'h7ffffe - 24'(c));
         repeat (2) @(negedge clk_i);
         check24(24'h800001 + 24'(c), cpu_rd_left_o[c]);
         check24(24'h7ffffe - 24'(c), cpu_rd_right_o[c]);
      end
      cpu_wr_stb_i[0] = 1'b1;
      cpu_wr_left_i[0] = 24'h00aa55;
      @(negedge clk_i);
      cpu_write(0, 24'h123456, 24'h654321);
      repeat (10) @(negedge clk_i);
      check24(24'h123456, cpu_rd_left_o[0]);
      tap_read(0, 3'h6, 24'h800002, 24'h7ffffd);
      $display("test cpu path done");
   endtask

   task automatic test_serial();
      sai0_src_sel_i = 3'h5;
      sai1_src_sel_i = 3'h6;
      fork
         abr_codec_model_i.play(24'hc0ffee, 24'h0badf0);
         abr_codec_model_b_i.play(24'h5a5a01, 24'ha5a5fe);
      join
      check24(24'h123456, abr_codec_model_i.rx_left);
      check24(24'h654321, abr_codec_model_i.rx_right);
      check24(24'h800002, abr_codec_model_b_i.rx_left);
      check24(24'h7ffffd, abr_codec_model_b_i.rx_right);
      tap_read(0, 3'h0, 24'hc0ffee, 24'h0badf0);
      tap_read(1, 3'h1, 24'h5a5a01, 24'ha5a5fe);
      tap_read(2, 3'h2, 24'h5a5a01, 24'ha5a5fe);
      $display("test serial done");
   endtask

   task automatic test_pass();
      iec_mode_i = ABR_OUT_PASS;
      for (int p = 0; p < 4; p++)
      begin
         iec_pass_sel_i = 2'(p);
         pass_pat = 4'h1 << p;
         repeat (5) @(negedge clk_i);
         check24(24'h1, {23'h0, iec_out_pro_o});
         check24(24'h1, {23'h0, iec_out_con_o});
         pass_pat = ~(4'h1 << p);
         repeat (5) @(negedge clk_i);
         check24(24'h0, {23'h0, iec_out_pro_o});
      end
      $display("test pass done");
   endtask

   task automatic test_link_loop();
      int n;
      iec_mode_i = ABR_OUT_GEN;
      iec_src_sel_i = 3'h6;
      iec_rx_pin_sel_i = {2'd1, 2'd0};
      loop_on = 1'b1;
      cpu_rd_sel_i = {3'h4, 3'h3, 3'h0};
      n = 0;
      while (n < 20000 && (cpu_rd_left_o[1] !== 24'h800002 ||
                           cpu_rd_right_o[2] !== 24'h7ffffd))
      begin
         @(negedge clk_i);
         n++;
      end
      check24(24'h800002, cpu_rd_left_o[1]);
      check24(24'h7ffffd, cpu_rd_right_o[2]);
      if (n >= 20000)
         tally_and_finish();
      else
         $display("test link loop done");
   endtask

   // cuts a hung run short
   initial
   begin
      #200000;
      error_cnt++;
      tally_and_finish();
   end

   // reset, then the scenarios in turn
   initial
   begin
      error_cnt = 0;
      checks_done = 0;
      resetn_i = 1'b0;
      sai_fmt_eiaj_i = 4'h0;
      sai0_src_sel_i = 3'h0;
      sai1_src_sel_i = 3'h0;
      pass_pat = 4'h0;
      loop_on = 1'b0;
      iec_rx_pin_sel_i = '0;
      iec_mode_i = ABR_OUT_GEN;
      iec_pass_sel_i = 2'h0;
      iec_src_sel_i = 3'h5;
      cpu_rd_sel_i = '0;
      cpu_wr_stb_i = 3'h0;
      cpu_wr_left_i = '0;
      cpu_wr_right_i = '0;
      repeat (10) @(negedge clk_i);
      resetn_i = 1'b1;
      test_cpu_path();
      test_serial();
      test_pass();
      test_link_loop();
      tally_and_finish();
   end
endmodule
